// ===== dmm_consts.svh
// constants for the deinterlace motion measure block
`ifndef DMM_CONSTS_SVH
`define DMM_CONSTS_SVH

// ----------------------------------------
// window geometry
// ----------------------------------------
`define DMM_LUMA_W 8
`define DMM_WIN_ROWS 9
`define DMM_WIN_COLS 6
`define DMM_ROW_ORIGIN 4
`define DMM_COL_ORIGIN 2

// ----------------------------------------
// arithmetic
// ----------------------------------------
`define DMM_TDM_W 13
`define DMM_Q_SHIFT_MIN 3'h4
`define DMM_Q_SHIFT_MAX 3'h6
`define DMM_R_SHIFT_MIN 4'h6
`define DMM_R_SHIFT_MAX 4'h8
`define DMM_SCM_DEN_SHIFT 4
`define DMM_EDGE_SHIFT 5
`define DMM_FILT_SHIFT 3
`define DMM_SMOOTH_ONE 9'h100
`define DMM_SMOOTH_SHIFT 8
`define DMM_RECIP_SCALE 255
`define DMM_RECIP_FRAC 8
`define DMM_DN_ROW_TOP_FIRST 2
`define DMM_DN_ROW_BOT_FIRST 1

// ----------------------------------------
// values
// ----------------------------------------
`define DMM_MOTION_MAX 8'hFF
`define DMM_MOTION_RESET 8'h00
`define DMM_TC1_TYPICAL 8'h40
`define DMM_TC2_TYPICAL 8'hC8

`endif

// ===== dmm_pkg.sv
// types shared by the deinterlace motion measure files
package dmm_pkg;
  `include "dmm_consts.svh"

  typedef logic [`DMM_LUMA_W-1:0] dmm_luma_t;
  typedef dmm_luma_t [`DMM_WIN_ROWS-1:0][`DMM_WIN_COLS-1:0] dmm_window_t;

  typedef struct packed {
    logic [2:0] quantise_shift;
    logic [3:0] range_shift;
    dmm_luma_t motion_offset;
    dmm_luma_t motion_threshold;
    dmm_luma_t first_time_constant;
    dmm_luma_t second_time_constant;
    dmm_luma_t edge_multiplier;
    logic denoise_enable;
    logic top_first;
    logic top_field;
    logic second_field;
  } dmm_cfg_t;

  typedef struct packed {
    logic valid;
    logic line_first;
    logic line_last;
    dmm_luma_t saved_motion;
  } dmm_tag_t;
endpackage

// ===== dmm_divider.sv
// reciprocal-table divider that turns a quantised difference into a motion value
`timescale 1ns/100ps
`include "dmm_consts.svh"
module dmm_divider (
  // operands
  input wire logic [8:0] numer,
  input wire logic [7:0] denom,
  input wire logic [3:0] range_shift,
  input wire logic [7:0] offset,
  // result
  output logic [7:0] quotient
);
  import dmm_pkg::*;

  logic [7:0] recip_table [0:255];
  logic [7:0] recip;
  logic [16:0] prod;
  logic [24:0] scaled;
  logic [16:0] ratio;
  logic [17:0] with_offset;

  // ----------------------------------------
  // reciprocal table
  // ----------------------------------------
  // entry zero is never used: a zero divisor saturates below
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_recip
      if (gi == 0) begin : g_zero
        assign recip_table[gi] = `DMM_MOTION_MAX;
      end else begin : g_entry
        assign recip_table[gi] = 8'(`DMM_RECIP_SCALE / gi);
      end
    end
  endgenerate

  // ----------------------------------------
  // multiply and saturate
  // ----------------------------------------
  // the table is truncated, so a divisor of 128 reads 1 in place of 1.99 and results can be nearly half too low
  always_comb begin
    recip = recip_table[denom];
    prod = 17'(numer * recip);
    scaled = 25'(prod) << range_shift;
    ratio = 17'(scaled >> `DMM_RECIP_FRAC);
    with_offset = 18'(ratio) + 18'(offset);
    if (denom == 8'h00 || with_offset > 18'(`DMM_MOTION_MAX)) begin
      quotient = `DMM_MOTION_MAX;
    end else begin
      quotient = with_offset[7:0];
    end
  end
endmodule

// ===== dmm_motion_measure.sv
// per-pair motion measure pipeline of the motion adaptive deinterlacer
`timescale 1ns/100ps
`include "dmm_consts.svh"

module dmm_motion_measure (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // configuration
  input wire dmm_pkg::dmm_cfg_t cfg,
  // pair stream
  input wire dmm_pkg::dmm_tag_t in_tag,
  input wire dmm_pkg::dmm_window_t cur_top_field,
  input wire dmm_pkg::dmm_window_t cur_bottom_field,
  input wire dmm_pkg::dmm_window_t cur_denoised,
  input wire dmm_pkg::dmm_window_t ref_previous_frame,
  input wire dmm_pkg::dmm_window_t ref_next_frame,
  // smoothed value to memory
  output logic smoothed_valid,
  output logic [7:0] smoothed_motion,
  // final value to the blend
  output logic final_valid,
  output logic [7:0] final_motion
);
  import dmm_pkg::*;

  // ----------------------------------------
  // window helpers
  // ----------------------------------------
  function automatic dmm_luma_t px(dmm_window_t w, int x, int y);
    return w[y + `DMM_ROW_ORIGIN][x + `DMM_COL_ORIGIN];
  endfunction

  function automatic dmm_luma_t absd(dmm_luma_t a, dmm_luma_t b);
    return (a > b) ? a - b : b - a;
  endfunction

  // same-field neighbours sit two rows away
  function automatic dmm_luma_t cross_filt(dmm_window_t w, int x, int y);
    logic [10:0] s;
    s = 11'({px(w, x, y), 1'b0});
    s = s + 11'(px(w, x - 1, y)) + 11'(px(w, x + 1, y));
    s = s + 11'({px(w, x, y - 2), 1'b0}) + 11'({px(w, x, y + 2), 1'b0});
    return 8'(s >> `DMM_FILT_SHIFT);
  endfunction

  // six terms of at most 255 fit eleven bits
  function automatic logic [10:0] vert_cplx(dmm_window_t w);
    logic [10:0] acc;
    acc = '0;
    for (int x = 0; x <= 1; x++) begin
      for (int y = 0; y <= 2; y++) begin
        acc = acc + 11'(absd(px(w, x, y), px(w, x, y - 2)));
      end
    end
    return acc;
  endfunction

  function automatic logic [11:0] horz_cplx(dmm_window_t w);
    logic [11:0] acc;
    acc = '0;
    for (int x = -1; x <= 1; x++) begin
      for (int y = -1; y <= 1; y++) begin
        acc = acc + 12'(absd(px(w, x, y), px(w, x + 1, y)));
      end
    end
    return acc;
  endfunction

  function automatic logic [10:0] edge_sum(dmm_window_t w);
    logic [10:0] acc;
    acc = '0;
    for (int y = -2; y <= 2; y++) begin
      acc = acc + 11'(absd(px(w, 0, y), px(w, 1, y)));
    end
    return acc;
  endfunction

  // twenty terms of at most 255 fit the 13-bit difference
  function automatic logic [12:0] temporal_diff(dmm_window_t c, dmm_window_t r);
    logic [12:0] acc;
    acc = '0;
    for (int x = -1; x <= 2; x++) begin
      for (int y = -2; y <= 2; y++) begin
        acc = acc + 13'(absd(cross_filt(c, x, y), cross_filt(r, x, y)));
      end
    end
    return acc;
  endfunction

  // ----------------------------------------
  // stage 1: assemble current and reference windows
  // ----------------------------------------
  dmm_window_t cur_raw;
  dmm_window_t cur_sel;
  dmm_window_t ref_sel;
  dmm_window_t cur_q;
  dmm_window_t ref_q;
  dmm_tag_t tag1_q;
  logic [2:0] dn_first_row;

  assign dn_first_row = cfg.top_first ? 3'(`DMM_DN_ROW_TOP_FIRST) : 3'(`DMM_DN_ROW_BOT_FIRST);

  // row index 4 is y = 0, so even indices are same-field rows
  genvar gr;
  generate
    for (gr = 0; gr < `DMM_WIN_ROWS; gr++) begin : g_row
      localparam logic EVEN_ROW = (gr % 2) == 0;
      assign cur_raw[gr] = (EVEN_ROW == cfg.top_field) ? cur_top_field[gr]
                                                      : cur_bottom_field[gr];
      assign cur_sel[gr] = (cfg.denoise_enable && 4'(gr) >= 4'(dn_first_row))
                           ? cur_denoised[gr] : cur_raw[gr];
    end
  endgenerate

  // the reference is always denoised upstream, regardless of row
  assign ref_sel = cfg.second_field ? ref_next_frame : ref_previous_frame;

  always_ff @(posedge clock) begin
    cur_q <= cur_sel;
    ref_q <= ref_sel;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tag1_q <= '0;
    end else begin
      tag1_q <= in_tag;
    end
  end

  // ----------------------------------------
  // stage 2: complexity and temporal sums
  // ----------------------------------------
  logic [10:0] vert_q;
  logic [11:0] horz_q;
  logic [10:0] edge_q;
  logic [12:0] tdm_q;
  dmm_tag_t tag2_q;

  // all four sums see the same registered window, so they stay aligned
  always_ff @(posedge clock) begin
    vert_q <= vert_cplx(cur_q);
    horz_q <= horz_cplx(cur_q);
    edge_q <= edge_sum(cur_q);
    tdm_q <= temporal_diff(cur_q, ref_q);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tag2_q <= '0;
    end else begin
      tag2_q <= tag1_q;
    end
  end

  // ----------------------------------------
  // stage 3: combined complexity and quantised difference
  // ----------------------------------------
  logic [18:0] edge_prod;
  logic [13:0] edge_cplx;
  logic [14:0] vh_sum;
  logic [14:0] scm;
  logic [2:0] q_shift;
  logic [7:0] den_q;
  logic [8:0] num_q;
  dmm_tag_t tag3_q;

  assign edge_prod = 19'(edge_q * cfg.edge_multiplier);
  assign edge_cplx = 14'(edge_prod >> `DMM_EDGE_SHIFT);
  assign vh_sum = 15'(vert_q) + 15'(horz_q);
  // subtract only when it cannot go negative
  assign scm = (vh_sum > 15'(edge_cplx)) ? vh_sum - 15'(edge_cplx) : 15'h0000;

  // out-of-range shifts are pinned to the nearest supported value
  always_comb begin
    if (cfg.quantise_shift < `DMM_Q_SHIFT_MIN) begin
      q_shift = `DMM_Q_SHIFT_MIN;
    end else if (cfg.quantise_shift > `DMM_Q_SHIFT_MAX) begin
      q_shift = `DMM_Q_SHIFT_MAX;
    end else begin
      q_shift = cfg.quantise_shift;
    end
  end

  // a flat window gives a zero divisor, which the divider saturates
  always_ff @(posedge clock) begin
    den_q <= 8'(scm >> `DMM_SCM_DEN_SHIFT);
    num_q <= 9'(tdm_q >> q_shift);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tag3_q <= '0;
    end else begin
      tag3_q <= tag2_q;
    end
  end

  // ----------------------------------------
  // stage 4: divide into the raw measure
  // ----------------------------------------
  logic [3:0] r_shift;
  logic [7:0] raw_d;
  logic [7:0] raw_q;
  dmm_tag_t tag4_q;

  always_comb begin
    if (cfg.range_shift < `DMM_R_SHIFT_MIN) begin
      r_shift = `DMM_R_SHIFT_MIN;
    end else if (cfg.range_shift > `DMM_R_SHIFT_MAX) begin
      r_shift = `DMM_R_SHIFT_MAX;
    end else begin
      r_shift = cfg.range_shift;
    end
  end

  dmm_divider u_divider (
    .numer(num_q),
    .denom(den_q),
    .range_shift(r_shift),
    .offset(cfg.motion_offset),
    .quotient(raw_d)
  );

  always_ff @(posedge clock) begin
    raw_q <= raw_d;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tag4_q <= '0;
    end else begin
      tag4_q <= tag3_q;
    end
  end

  // ----------------------------------------
  // stage 5: smoothing against the saved value
  // ----------------------------------------
  // above the threshold the caller's smaller constant lets motion rise fast
  logic [7:0] k;
  logic [8:0] k_inv;
  logic [17:0] blend_sum;
  logic [7:0] smooth_d;

  assign k = (raw_q > cfg.motion_threshold) ? cfg.first_time_constant
                                            : cfg.second_time_constant;
  assign k_inv = `DMM_SMOOTH_ONE - 9'(k);
  assign blend_sum = 18'(k * tag4_q.saved_motion) + 18'(k_inv * raw_q);
  assign smooth_d = 8'(blend_sum >> `DMM_SMOOTH_SHIFT);

  always_ff @(posedge clock) begin
    if (reset) begin
      smoothed_valid <= 1'b0;
    end else begin
      smoothed_valid <= tag4_q.valid;
    end
  end

  // the value stands between pulses; idle cycles carry stale datapath values
  always_ff @(posedge clock) begin
    if (reset) begin
      smoothed_motion <= `DMM_MOTION_RESET;
    end else if (tag4_q.valid) begin
      smoothed_motion <= smooth_d;
    end
  end

  logic tag5_first_q;
  logic tag5_last_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      tag5_first_q <= 1'b0;
      tag5_last_q <= 1'b0;
    end else begin
      tag5_first_q <= tag4_q.line_first;
      tag5_last_q <= tag4_q.line_last;
    end
  end

  // ----------------------------------------
  // stage 6: horizontal maximum over three pairs
  // ----------------------------------------
  // a pair waits for its right neighbour; a line's last pair is
  // flushed one cycle later, even in a cycle where a new pair arrives
  function automatic logic [7:0] max3(logic [7:0] a, logic [7:0] b, logic [7:0] c);
    logic [7:0] m;
    m = (a > b) ? a : b;
    return (m > c) ? m : c;
  endfunction

  logic [7:0] left_q;
  logic [7:0] mid_q;
  logic mid_valid_q;
  logic mid_last_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      left_q <= `DMM_MOTION_RESET;
      mid_q <= `DMM_MOTION_RESET;
    end else if (smoothed_valid) begin
      // a line edge has no outer neighbour, so the pair stands in for it
      left_q <= (tag5_first_q || !mid_valid_q || mid_last_q) ? smoothed_motion : mid_q;
      mid_q <= smoothed_motion;
    end
  end

  // the middle slot empties only once a line's last pair has been flushed
  always_ff @(posedge clock) begin
    if (reset) begin
      mid_valid_q <= 1'b0;
      mid_last_q <= 1'b0;
    end else if (smoothed_valid) begin
      mid_valid_q <= 1'b1;
      mid_last_q <= tag5_last_q;
    end else if (mid_valid_q && mid_last_q) begin
      mid_valid_q <= 1'b0;
      mid_last_q <= 1'b0;
    end
  end

  // one pulse per pair: its right neighbour has arrived or its line has ended
  always_ff @(posedge clock) begin
    if (reset) begin
      final_valid <= 1'b0;
    end else begin
      final_valid <= mid_valid_q && (mid_last_q || smoothed_valid);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      final_motion <= `DMM_MOTION_RESET;
    end else if (mid_valid_q && mid_last_q) begin
      final_motion <= max3(left_q, mid_q, mid_q);
    end else if (mid_valid_q && smoothed_valid) begin
      final_motion <= max3(left_q, mid_q, smoothed_motion);
    end
  end
endmodule

// ===== dmm_frame_mem.sv
// frame memory model that keeps smoothed values for the next frame
`timescale 1ns/100ps
module dmm_frame_mem (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // writes from the measure block
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rewind,
  // reads for the next frame
  input wire logic [3:0] rd_index,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [16];
  logic [3:0] wr_ptr_q;
  assign rd_data = mem_q[rd_index];
  // one place per pair, in pair order; rewind marks a new frame
  always_ff @(posedge clock) begin
    if (reset || rewind) begin
      wr_ptr_q <= 4'h0;
    end else if (wr_valid) begin
      mem_q[wr_ptr_q] <= wr_data;
      wr_ptr_q <= wr_ptr_q + 4'h1;
    end
  end
endmodule

// ===== dmm_motion_measure_sva.sv
// assertion checker for the motion measure pipeline
`timescale 1ns/100ps
module dmm_motion_measure_sva (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // watched ports
  input wire dmm_pkg::dmm_cfg_t cfg,
  input wire dmm_pkg::dmm_tag_t in_tag,
  input wire logic smoothed_valid,
  input wire logic [7:0] smoothed_motion,
  input wire logic final_valid,
  input wire logic [7:0] final_motion
);
  import dmm_pkg::*;
  logic [3:0] bal_q;
  logic [15:0] k_lo;
  // smaller constant bounds the weighted average from both sides
  assign k_lo = 16'(cfg.first_time_constant < cfg.second_time_constant ?
    cfg.first_time_constant : cfg.second_time_constant);
  always_ff @(posedge clock) begin
    if (reset) begin
      bal_q <= 4'h0;
    end else begin
      bal_q <= bal_q + 4'(smoothed_valid) - 4'(final_valid);
    end
  end
  default clocking dmm_cb @(posedge clock); endclocking
  default disable iff (reset);
  a_smooth_latency: assert property (in_tag.valid |-> ##5 smoothed_valid)
    else $error("smoothed value late");
  a_smooth_gap: assert property (!in_tag.valid |-> ##5 !smoothed_valid)
    else $error("smoothed pulse without pair");
  a_last_final: assert property (in_tag.valid && in_tag.line_last |-> ##[6:7] final_valid)
    else $error("final value missing at line end");
  a_final_balance: assert property (final_valid |-> bal_q != 4'h0)
    else $error("final value without smoothed value");
  a_smooth_bounds: assert property (smoothed_valid |->
    16'(smoothed_motion) >= ((k_lo * 16'($past(in_tag.saved_motion, 5))) >> 8) &&
    16'(smoothed_motion) <= ((k_lo * 16'($past(in_tag.saved_motion, 5))
      + (16'h100 - k_lo) * 16'h00FF) >> 8))
    else $error("smoothed value outside weighted range");
  a_smooth_hold: assert property (!smoothed_valid && !$past(reset) |-> $stable(smoothed_motion))
    else $error("smoothed value moved without pulse");
  a_final_hold: assert property (!final_valid && !$past(reset) |-> $stable(final_motion))
    else $error("final value moved without pulse");
  a_reset_clears: assert property (disable iff (1'b0) reset |=>
    !smoothed_valid && !final_valid && smoothed_motion == 8'h00 && final_motion == 8'h00)
    else $error("outputs not cleared by reset");
  c_multi_pair: cover property (in_tag.valid && in_tag.line_first && !in_tag.line_last);
  c_saturated: cover property (smoothed_valid && smoothed_motion == 8'hFF);
  c_final_run: cover property (final_valid ##1 final_valid);
endmodule
bind dmm_motion_measure dmm_motion_measure_sva u_sva (
  .clock(clock), .reset(reset), .cfg(cfg), .in_tag(in_tag),
  .smoothed_valid(smoothed_valid), .smoothed_motion(smoothed_motion),
  .final_valid(final_valid), .final_motion(final_motion));

// ===== tb.sv
// self-checking testbench for the motion measure pipeline
`timescale 1ns/100ps
module tb;
  import dmm_pkg::*;
  typedef int dmm_grid_t [9][6];
  typedef struct packed {
    logic [3:0] pic;
    logic [2:0] qs;
    logic [3:0] rs;
    logic [3:0] modes;
    logic [7:0] offset;
    logic [7:0] thr;
    logic [7:0] saved;
  } dmm_row_t;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic rewind = 1'b0;
  logic smoothed_valid, final_valid;
  logic [7:0] smoothed_motion, final_motion, rd_data;
  logic [3:0] rd_index = 4'h0;
  dmm_cfg_t cfg;
  dmm_tag_t in_tag;
  dmm_window_t w_top, w_bot, w_dn, w_prev, w_next;
  int err_count = 0;
  int num_checks = 0;
  logic [7:0] sq[$];
  logic [7:0] fq[$];
  logic [7:0] eq[$];
  logic [7:0] s_exp[3];
  // modes: denoise, top first, top field, second field; picture 0 is flat
  dmm_row_t rows[8] = '{
    '{4'h0, 3'h4, 4'h6, 4'h0, 8'h00, 8'h10, 8'h80},
    '{4'h1, 3'h4, 4'h6, 4'h8, 8'h05, 8'hFF, 8'h20},
    '{4'h2, 3'h5, 4'h7, 4'h4, 8'h00, 8'h00, 8'hF0},
    '{4'h3, 3'h6, 4'h8, 4'h2, 8'h10, 8'h30, 8'h00},
    '{4'h4, 3'h7, 4'h9, 4'h1, 8'h00, 8'hFF, 8'h55},
    '{4'h5, 3'h3, 4'h5, 4'hC, 8'h20, 8'h08, 8'hAA},
    '{4'h6, 3'h5, 4'h8, 4'hB, 8'h00, 8'hFF, 8'h01},
    '{4'h7, 3'h6, 4'h6, 4'hF, 8'hFF, 8'h00, 8'hFE}};

  dmm_motion_measure DUT (.clock(clock), .reset(reset), .cfg(cfg), .in_tag(in_tag),
    .cur_top_field(w_top), .cur_bottom_field(w_bot), .cur_denoised(w_dn),
    .ref_previous_frame(w_prev), .ref_next_frame(w_next),
    .smoothed_valid(smoothed_valid), .smoothed_motion(smoothed_motion),
    .final_valid(final_valid), .final_motion(final_motion));
  dmm_frame_mem u_mem (.clock(clock), .reset(reset), .wr_valid(smoothed_valid),
    .wr_data(smoothed_motion), .rewind(rewind), .rd_index(rd_index), .rd_data(rd_data));

  always #2 clock = ~clock;
  always @(negedge clock) begin
    if (smoothed_valid === 1'b1)
      sq.push_back(smoothed_motion);
    if (final_valid === 1'b1)
      fq.push_back(final_motion);
  end

  // ----------------------------------------
  // reference arithmetic
  // ----------------------------------------
  function automatic int ab(int x);
    return x < 0 ? -x : x;
  endfunction
  function automatic int flt(dmm_grid_t a, int r, int c);
    return (2 * a[r][c] + a[r][c-1] + a[r][c+1] + 2 * a[r-2][c] + 2 * a[r+2][c]) >> 3;
  endfunction
  function automatic logic [7:0] raw_of();
    dmm_grid_t cu, rf;
    int v = 0, h = 0, e = 0, t = 0, den, q;
    foreach (cu[r, c]) begin
      cu[r][c] = (cfg.denoise_enable && r >= (cfg.top_first ? 2 : 1)) ? w_dn[r][c] :
        (((r % 2) == 0) == cfg.top_field) ? w_top[r][c] : w_bot[r][c];
      rf[r][c] = cfg.second_field ? w_next[r][c] : w_prev[r][c];
    end
    foreach (cu[r, c]) begin
      if (r >= 4 && r <= 6 && c >= 2 && c <= 3)
        v += ab(cu[r][c] - cu[r-2][c]);
      if (r >= 3 && r <= 5 && c >= 1 && c <= 3)
        h += ab(cu[r][c] - cu[r][c+1]);
      if (r >= 2 && r <= 6 && c == 2)
        e += ab(cu[r][2] - cu[r][3]);
      if (r >= 2 && r <= 6 && c >= 1 && c <= 4)
        t += ab(flt(cu, r, c) - flt(rf, r, c));
    end
    e = (e * cfg.edge_multiplier) >> 5;
    den = (v + h - e < 0) ? 0 : (v + h - e) >> 4;
    q = cfg.quantise_shift < 4 ? 4 : cfg.quantise_shift > 6 ? 6 : cfg.quantise_shift;
    t = t >> q;
    q = cfg.range_shift < 6 ? 6 : cfg.range_shift > 8 ? 8 : cfg.range_shift;
    if (den == 0)
      return 8'hFF;
    t = (((t * (255 / den)) << q) >> 8) + cfg.motion_offset;
    return t > 255 ? 8'hFF : 8'(t);
  endfunction
  function automatic logic [7:0] smooth(logic [7:0] raw, logic [7:0] saved);
    int k;
    k = raw > cfg.motion_threshold ? cfg.first_time_constant : cfg.second_time_constant;
    return 8'((k * saved + (256 - k) * raw) >> 8);
  endfunction

  // ----------------------------------------
  // drivers and checks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic send(input logic first, input logic last, input logic [7:0] sv,
    input logic [3:0] s);
    @(negedge clock);
    for (int r = 0; r < 9; r++) begin
      for (int c = 0; c < 6; c++) begin
        w_top[r][c] = s == 0 ? 8'h64 : 8'(r * 37 + c * 13 + s * 29);
        w_bot[r][c] = s == 0 ? 8'h64 : 8'(r * 5 + c * 61 + s * 3 + 90);
        w_dn[r][c] = s == 0 ? 8'h64 : 8'(r * 23 + c * 7 + s * 41);
        w_prev[r][c] = 8'(r * 11 + c * 19 + s * 17 + 40);
        w_next[r][c] = 8'(r * 3 + c * 29 + s * 7 + 200);
      end
    end
    in_tag = '{1'b1, first, last, sv};
    eq.push_back(smooth(raw_of(), sv));
  endtask
  task automatic idle_wait(input int n);
    @(negedge clock);
    in_tag.valid = 1'b0;
    for (int i = 0; i < 100 && fq.size() < n; i++)
      @(negedge clock);
    if (fq.size() < n) begin
      check(8'h00, 8'h01, "timeout");
      results();
    end
  endtask
  task automatic run_line(input logic use_mem);
    logic [7:0] m;
    @(negedge clock);
    rewind = 1'b1;
    @(negedge clock);
    rewind = 1'b0;
    for (int p = 0; p < 3; p++) begin
      rd_index = 4'(p);
      #1;
      if (use_mem) begin
        check(rd_data, s_exp[p], "readback");
      end
      send(p == 0, p == 2, use_mem ? rd_data : 8'h30, 4'(p + 9));
    end
    idle_wait(3);
    for (int p = 0; p < 3; p++) begin
      s_exp[p] = eq.pop_front();
      check(sq.pop_front(), s_exp[p], "smoothed");
    end
    for (int p = 0; p < 3; p++) begin
      m = s_exp[p];
      if (p > 0 && s_exp[p-1] > m)
        m = s_exp[p-1];
      if (p < 2 && s_exp[p+1] > m)
        m = s_exp[p+1];
      check(fq.pop_front(), m, "final");
    end
  endtask

  initial begin
    cfg = '0;
    cfg.first_time_constant = 8'h40;
    cfg.second_time_constant = 8'hC8;
    cfg.edge_multiplier = 8'h10;
    in_tag = '0;
    w_top = '0;
    w_bot = '0;
    w_dn = '0;
    w_prev = '0;
    w_next = '0;
    repeat (6) @(negedge clock);
    reset = 1'b0;
    foreach (rows[i]) begin
      {cfg.denoise_enable, cfg.top_first, cfg.top_field, cfg.second_field} = rows[i].modes;
      {cfg.quantise_shift, cfg.range_shift} = {rows[i].qs, rows[i].rs};
      {cfg.motion_offset, cfg.motion_threshold} = {rows[i].offset, rows[i].thr};
      send(1'b1, 1'b1, rows[i].saved, rows[i].pic);
      idle_wait(1);
      s_exp[0] = eq.pop_front();
      check(sq.pop_front(), s_exp[0], "smoothed");
      check(fq.pop_front(), s_exp[0], "single final");
    end
    // full edge weight drives the combined complexity of the line's last pair (picture 11) to its zero clamp
    cfg.edge_multiplier = 8'hFF;
    run_line(1'b0);
    run_line(1'b1);
    // a pair in flight is dropped by a reset
    send(1'b1, 1'b1, 8'h10, 4'h3);
    @(negedge clock);
    in_tag.valid = 1'b0;
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    repeat (10) @(negedge clock);
    check(8'(sq.size() + fq.size()), 8'h00, "pulse after reset");
    check(smoothed_motion, 8'h00, "smoothed after reset");
    check(final_motion, 8'h00, "final after reset");
    results();
  end
endmodule
